// ### rtl/tvi_defs.svh
/*
 holds: offsets, field positions, reset values and timing counts of the text inserter
 assumes: included by its bare name from the package and the design files
*/
`ifndef TVI_DEFS_SVH
`define TVI_DEFS_SVH

// register byte addresses
`define TVI_REG_CTRL        12'h000
`define TVI_REG_REQ_TIMING  12'h004
`define TVI_REG_LINE_SEL_LO 12'h008
`define TVI_REG_LINE_SEL_HI 12'h00c
`define TVI_REG_STATUS      12'h010

// control fields
`define TVI_CTRL_ENABLE_BIT 0
`define TVI_CTRL_WIDTH_LSB  4
`define TVI_CTRL_WIDTH_W    4
// request timing fields
`define TVI_REQ_RISE_LSB    0
`define TVI_REQ_FALL_LSB    16
`define TVI_REQ_FIELD_W     12

// reset values
`define TVI_CTRL_RESET      32'h0000_0000
`define TVI_REQ_RISE_RESET  12'h000
`define TVI_REQ_FALL_RESET  12'h000
`define TVI_LINE_SEL_RESET  32'h0000_0000

// timing
`define TVI_SYS_CLK_KHZ     27000
`define TVI_SYNC_TO_TEXT_NS 10200
`define TVI_SYNC_TO_TEXT_CYCLES ((`TVI_SYNC_TO_TEXT_NS * `TVI_SYS_CLK_KHZ) / 1000000)
`define TVI_TEXT_BITS       360
`define TVI_GROUP_BITS      37
`define TVI_GROUP_CLOCKS    144
`define TVI_SHORT_SPACING   9
`define TVI_SHORT_FIRST     10
`define TVI_SAMPLE_PHASE    1
`define TVI_WIDTH_STEP_BITS 8

`endif

// ### rtl/tvi_pkg.sv
/*
 holds: types shared by the text inserter files
 assumes: tvi_defs.svh is on the include path
*/
`include "tvi_defs.svh"

package tvi_pkg;

    typedef enum logic [1:0]
    {
        TVI_IDLE,
        TVI_WAIT,
        TVI_SEND
    } tvi_state_t;

    typedef struct packed
    {
        logic [8:0] index;
        logic       bit_val;
    } tvi_word_t;

    typedef struct packed
    {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } tvi_apb_req_t;

endpackage : tvi_pkg

// ### rtl/tvi_sync3.sv
/*
 holds: three-flop pin synchroniser with agreement filter
 assumes: input is asynchronous to clk
*/
`timescale 1ns/1ps
`default_nettype none

module tvi_sync3
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and synchronised level
    input  wire logic pin,
    output var  logic level
);

    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb
    begin
        next_stage = {stage[1:0], pin};
        // first flop only feeds the second
        next_level = (stage[2] == stage[1]) ? stage[1] : level;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage <= 3'h0;
            level <= 1'h0;
        end
        else
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end

endmodule : tvi_sync3

`default_nettype wire

// ### rtl/tvi_buf2.sv
/*
 holds: two-entry valid/ready buffer for captured text bits
 assumes: single clock, synchronous reset
*/
`timescale 1ns/1ps
`default_nettype none

module tvi_buf2
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire tvi_pkg::tvi_word_t in_data,
    // drain side
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  tvi_pkg::tvi_word_t out_data
);

    tvi_pkg::tvi_word_t mem [0:1];
    tvi_pkg::tvi_word_t next_mem0;
    tvi_pkg::tvi_word_t next_mem1;
    logic               wr_ptr;
    logic               rd_ptr;
    logic [1:0]         count;
    logic               next_wr_ptr;
    logic               next_rd_ptr;
    logic [1:0]         next_count;
    tvi_pkg::tvi_word_t next_out;
    logic               push;
    logic               pop;

    always_comb
    begin
        in_ready    = (count != 2'h2);
        out_valid   = (count != 2'h0);
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_mem0   = (push && !wr_ptr) ? in_data : mem[0];
        next_mem1   = (push && wr_ptr) ? in_data : mem[1];
        next_wr_ptr = push ? !wr_ptr : wr_ptr;
        next_rd_ptr = pop ? !rd_ptr : rd_ptr;
        next_count  = count + {1'h0, push} - {1'h0, pop};
        // read data come from a register
        next_out    = (next_count == 2'h0) ? out_data :
                      (next_rd_ptr ? next_mem1 : next_mem0);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem[0]   <= '0;
            mem[1]   <= '0;
            wr_ptr   <= 1'h0;
            rd_ptr   <= 1'h0;
            count    <= 2'h0;
            out_data <= '0;
        end
        else
        begin
            mem[0]   <= next_mem0;
            mem[1]   <= next_mem1;
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            out_data <= next_out;
        end
    end

endmodule : tvi_buf2

`default_nettype wire

// ### rtl/tvi_inserter.sv
/*
 holds: teletext line inserter: request window, bit cadence, capture, line select, APB regs
 assumes: 27 MHz system clock, hsync_lead pulse from the video timing generator,
          line_number from the same generator, sample stream drained by the interpolator
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
// Functional notes
// - text starts 10.2 us after sync lead
// - request edges programmable; source honours own delay
// - request window fits 360 bits
// - no window while enable bit clear
// - 37 bits map to 144 clocks
// - bits 10,19,28,37 three clocks, others four
// - cadence repeats each group until 360
// - sequencer feeds interpolator with phased bits
// - same timing every line; per-line select
`timescale 1ns/1ps
`default_nettype none
`include "tvi_defs.svh"

module tvi_inserter
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // video timing
    input  wire logic        hsync_lead,
    input  wire logic [5:0]  line_number,
    // text source pins
    input  wire logic        text_serial_input,
    output var  logic        text_request_out,
    // bit stream to interpolation filter
    output var  logic        bit_valid,
    input  wire logic        bit_ready,
    output var  logic        bit_value,
    output var  logic [8:0]  bit_index,
    output var  logic        insert_active
);

    localparam logic [11:0] SYNC_DELAY = 12'(`TVI_SYNC_TO_TEXT_CYCLES);
    localparam logic [8:0]  LAST_BIT   = 9'(`TVI_TEXT_BITS - 1);
    localparam logic [5:0]  GROUP_LAST = 6'(`TVI_GROUP_BITS - 1);

    // three-clock bits sit at 1-based positions 10,19,28,37 of each group
    function automatic logic is_short_bit(input logic [5:0] pos);
        logic [5:0] p1;
        p1 = pos + 6'h1;
        is_short_bit = (p1 == 6'd10) || (p1 == 6'd19) || (p1 == 6'd28) || (p1 == 6'd37);
    endfunction : is_short_bit

    function automatic logic addr_is(input logic [31:0] a, input logic [11:0] off);
        addr_is = (a[31:12] == 20'h0) && (a[11:0] == off);
    endfunction : addr_is

    // registers
    logic [31:0] ctrl;
    logic [11:0] req_rise;
    logic [11:0] req_fall;
    logic [31:0] line_sel_lo;
    logic [31:0] line_sel_hi;
    logic [31:0] next_ctrl;
    logic [11:0] next_req_rise;
    logic [11:0] next_req_fall;
    logic [31:0] next_line_sel_lo;
    logic [31:0] next_line_sel_hi;
    logic [31:0] next_prdata;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    // sequencer
    tvi_pkg::tvi_state_t state;
    tvi_pkg::tvi_state_t next_state;
    logic [11:0] line_cnt;
    logic [11:0] next_line_cnt;
    logic [8:0]  bit_cnt;
    logic [8:0]  next_bit_cnt;
    logic [5:0]  grp_pos;
    logic [5:0]  next_grp_pos;
    logic [1:0]  phase;
    logic [1:0]  next_phase;
    logic        req;
    logic        next_req;
    logic        overrun;
    logic        next_overrun;
    logic [8:0]  bit_limit;
    logic        line_on;
    logic        enable;
    logic        text_in;
    logic        cap_valid;
    logic        cap_ready;
    logic        bit_end;
    tvi_pkg::tvi_word_t cap_word;
    tvi_pkg::tvi_word_t out_word;

    assign enable = ctrl[`TVI_CTRL_ENABLE_BIT];
    // width field nonzero trims the window by steps of eight bits
    assign bit_limit = LAST_BIT - 9'(ctrl[`TVI_CTRL_WIDTH_LSB +: `TVI_CTRL_WIDTH_W]
                       * `TVI_WIDTH_STEP_BITS);
    assign line_on = line_number[5] ? line_sel_hi[line_number[4:0]]
                                    : line_sel_lo[line_number[4:0]];

    tvi_sync3 u_sync
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (text_serial_input),
        .level (text_in)
    );

    // apb: zero wait states, unmapped addresses answer with pslverr
    always_comb
    begin
        addr_ok = addr_is(paddr, `TVI_REG_CTRL) || addr_is(paddr, `TVI_REG_REQ_TIMING)
               || addr_is(paddr, `TVI_REG_LINE_SEL_LO) || addr_is(paddr, `TVI_REG_LINE_SEL_HI)
               || addr_is(paddr, `TVI_REG_STATUS);
        pready  = 1'h1;
        pslverr = psel && penable && !addr_ok;
        wr_en   = psel && penable && pwrite && addr_ok;
        rd_en   = psel && !penable && !pwrite;
        next_ctrl        = ctrl;
        next_req_rise    = req_rise;
        next_req_fall    = req_fall;
        next_line_sel_lo = line_sel_lo;
        next_line_sel_hi = line_sel_hi;
        if (wr_en && addr_is(paddr, `TVI_REG_CTRL))
            next_ctrl = pwdata & 32'h0000_00f1;
        if (wr_en && addr_is(paddr, `TVI_REG_REQ_TIMING))
        begin
            next_req_rise = pwdata[`TVI_REQ_RISE_LSB +: `TVI_REQ_FIELD_W];
            next_req_fall = pwdata[`TVI_REQ_FALL_LSB +: `TVI_REQ_FIELD_W];
        end
        if (wr_en && addr_is(paddr, `TVI_REG_LINE_SEL_LO))
            next_line_sel_lo = pwdata;
        if (wr_en && addr_is(paddr, `TVI_REG_LINE_SEL_HI))
            next_line_sel_hi = pwdata;
        next_prdata = prdata;
        if (rd_en)
        begin
            if (addr_is(paddr, `TVI_REG_CTRL))
                next_prdata = ctrl;
            else if (addr_is(paddr, `TVI_REG_REQ_TIMING))
                next_prdata = {4'h0, req_fall, 4'h0, req_rise};
            else if (addr_is(paddr, `TVI_REG_LINE_SEL_LO))
                next_prdata = line_sel_lo;
            else if (addr_is(paddr, `TVI_REG_LINE_SEL_HI))
                next_prdata = line_sel_hi;
            else if (addr_is(paddr, `TVI_REG_STATUS))
                next_prdata = {11'h0, overrun, 2'h0, state, 7'h0, bit_cnt};
            else
                next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl        <= `TVI_CTRL_RESET;
            req_rise    <= `TVI_REQ_RISE_RESET;
            req_fall    <= `TVI_REQ_FALL_RESET;
            line_sel_lo <= `TVI_LINE_SEL_RESET;
            line_sel_hi <= `TVI_LINE_SEL_RESET;
            prdata      <= 32'h0000_0000;
        end
        else
        begin
            ctrl        <= next_ctrl;
            req_rise    <= next_req_rise;
            req_fall    <= next_req_fall;
            line_sel_lo <= next_line_sel_lo;
            line_sel_hi <= next_line_sel_hi;
            prdata      <= next_prdata;
        end
    end

    // bit end: three-clock bits end at phase 2, others at phase 3
    assign bit_end = is_short_bit(grp_pos) ? (phase == 2'h2) : (phase == 2'h3);
    // capture at one fixed phase reached by both lengths
    assign cap_valid = (state == tvi_pkg::TVI_SEND) && (phase == 2'(`TVI_SAMPLE_PHASE));
    assign cap_word  = '{index: bit_cnt, bit_val: text_in};

    always_comb
    begin
        next_state    = state;
        next_line_cnt = line_cnt;
        next_bit_cnt  = bit_cnt;
        next_grp_pos  = grp_pos;
        next_phase    = phase;
        next_req      = req;
        // sticky until a selected line starts while enabled; a word captured while the buffer is full is dropped
        next_overrun  = overrun || (cap_valid && !cap_ready);
        if (line_cnt != 12'hfff)
            next_line_cnt = line_cnt + 12'h1;
        // request edges count from sync lead
        if (line_cnt == req_rise && state != tvi_pkg::TVI_IDLE)
            next_req = 1'h1;
        if (line_cnt == req_fall)
            next_req = 1'h0;
        case (state)
            tvi_pkg::TVI_IDLE:
            begin
                next_req = 1'h0;
                if (hsync_lead && enable && line_on)
                begin
                    next_state    = tvi_pkg::TVI_WAIT;
                    next_line_cnt = 12'h0;
                    next_overrun  = 1'h0;
                end
            end
            tvi_pkg::TVI_WAIT:
            begin
                // same placement every line; SEND starts SYNC_DELAY clocks after sync lead, first bit shows two clocks later
                if (line_cnt == SYNC_DELAY - 12'h1)
                begin
                    next_state   = tvi_pkg::TVI_SEND;
                    next_bit_cnt = 9'h0;
                    next_grp_pos = 6'h0;
                    next_phase   = 2'h0;
                end
            end
            tvi_pkg::TVI_SEND:
            begin
                next_phase = phase + 2'h1;
                if (bit_end)
                begin
                    next_phase   = 2'h0;
                    // 37 bits then wrap: 33*4+4*3 = 144 clocks
                    next_grp_pos = (grp_pos == GROUP_LAST) ? 6'h0 : grp_pos + 6'h1;
                    next_bit_cnt = bit_cnt + 9'h1;
                    if (bit_cnt == bit_limit)
                    begin
                        next_state = tvi_pkg::TVI_IDLE;
                        next_req   = 1'h0;
                    end
                end
            end
            default:
            begin
                next_state = tvi_pkg::TVI_IDLE;
            end
        endcase
        if (!enable)
        begin
            next_state = tvi_pkg::TVI_IDLE;
            next_req   = 1'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state    <= tvi_pkg::TVI_IDLE;
            line_cnt <= 12'h0;
            bit_cnt  <= 9'h0;
            grp_pos  <= 6'h0;
            phase    <= 2'h0;
            req      <= 1'h0;
            overrun  <= 1'h0;
        end
        else
        begin
            state    <= next_state;
            line_cnt <= next_line_cnt;
            bit_cnt  <= next_bit_cnt;
            grp_pos  <= next_grp_pos;
            phase    <= next_phase;
            req      <= next_req;
            overrun  <= next_overrun;
        end
    end

    assign text_request_out = req;
    assign insert_active    = (state == tvi_pkg::TVI_SEND);

    // buffered hand-off to the interpolator
    tvi_buf2 u_buf
    (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (cap_word),
        .out_valid (bit_valid),
        .out_ready (bit_ready),
        .out_data  (out_word)
    );

    assign bit_value = out_word.bit_val;
    assign bit_index = out_word.index;

endmodule : tvi_inserter

`default_nettype wire

// ### verif/tvi_chk_assertions.sv
/*
 holds: port checker for the text inserter
 assumes: bound onto tvi_inserter, one clock, sync reset
*/
`timescale 1ns/1ps
`default_nettype none
module tvi_chk
(
    // clock, reset, apb
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [31:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // video and text pins
    input wire logic        hsync_lead,
    input wire logic [5:0]  line_number,
    input wire logic        text_serial_input,
    input wire logic        text_request_out,
    // bit stream
    input wire logic        bit_valid,
    input wire logic        bit_ready,
    input wire logic        bit_value,
    input wire logic [8:0]  bit_index,
    input wire logic        insert_active
);
    logic        en_q;
    logic        stalled;
    logic [11:0] rise_q;
    logic [11:0] fall_q;
    logic [11:0] since;
    wire         wr_go = psel && penable && pwrite;

    // shadows of enable and request edges; cycles since the sync lead
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            en_q    <= 1'b0;
            rise_q  <= 12'h000;
            fall_q  <= 12'h000;
            since   <= 12'hfff;
            stalled <= 1'b0;
        end
        else
        begin
            if (wr_go && paddr == 32'h0000_0000)
                en_q <= pwdata[0];
            if (wr_go && paddr == 32'h0000_0004)
            begin
                rise_q <= pwdata[11:0];
                fall_q <= pwdata[27:16];
            end
            since   <= hsync_lead ? 12'h000 : since + {11'h000, since != 12'hfff};
            // a stall shifts the stream, so timing is only judged until the first stall of a line
            stalled <= (stalled && !hsync_lead) || (bit_valid && !bit_ready);
        end
    end

    // bit 0 shows at count 277, then four clocks a bit less the short ones
    function automatic logic [11:0] bit_at(input logic [8:0] n);
        int r = n % 37;
        return 12'(277 + 4 * n - 4 * (n / 37) - (r > 9) - (r > 18) - (r > 27));
    endfunction : bit_at

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_off;
        !en_q [*3];
    endsequence

    chk_apb_ready: assert property (psel && penable |-> pready)
        else $error("apb access without ready");
    chk_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 32'h0000_0010))
        else $error("slave error does not match address");
    chk_reset_quiet: assert property ($fell(rst) |-> !bit_valid && !text_request_out)
        else $error("outputs busy after reset");
    chk_off_quiet: assert property (s_off |-> !text_request_out && !insert_active)
        else $error("window open while disabled");
    chk_bit_cadence: assert property (bit_valid && !stalled |-> since == bit_at(bit_index))
        else $error("bit out of cadence");
    chk_index_range: assert property (bit_valid |-> bit_index < 9'h168)
        else $error("bit index beyond line");
    chk_req_rise: assert property ($rose(text_request_out) |-> since == rise_q + 12'h001)
        else $error("request rose at wrong cycle");
    chk_req_fall: assert property ($fell(text_request_out) && en_q
        |-> since == fall_q + 12'h001 || $fell(insert_active))
        else $error("request fell at wrong cycle");
endmodule : tvi_chk
`default_nettype wire

// ### verif/tvi_text_src.sv
/*
 holds: model of the external text source
 assumes: driven by the inserter's request, level picked by the bench
*/
`timescale 1ns/1ps
`default_nettype none
module tvi_text_src
#(
    parameter int DELAY = 3
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // request in, serial text out
    input  wire logic req,
    input  wire logic level,
    output var  logic ser
);
    logic [7:0] age;

    always_ff @(posedge clk)
    begin
        if (rst || !req)
            age <= 8'h00;
        else if (age != 8'hff)
            age <= age + 8'h01;
    end

    // before its pipeline delay, or outside the request, the pin shows the inverse
    assign ser = (req && age >= DELAY) ? level : !level;
endmodule : tvi_text_src
`default_nettype wire

// ### verif/tvi_inserter_bench.sv
/*
 holds: self-checking bench for the text inserter
 assumes: rtl on the include path, source model and checker compiled first
*/
`timescale 1ns/1ps
`default_nettype none
`include "tvi_defs.svh"
module tvi_inserter_bench;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, hsync_lead;
    logic        ser, req, bit_valid, bit_ready, bit_value, insert_active, level, last_err;
    logic [31:0] paddr, pwdata, prdata, rd_q;
    logic [8:0]  bit_index;
    logic [5:0]  line_number;
    int          errors, check_count, got, bad, req_hi;

    tvi_inserter uut
    (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hsync_lead(hsync_lead), .line_number(line_number),
        .text_serial_input(ser), .text_request_out(req), .bit_valid(bit_valid),
        .bit_ready(bit_ready), .bit_value(bit_value), .bit_index(bit_index),
        .insert_active(insert_active)
    );
    tvi_text_src #(.DELAY(3)) src
    (
        .clk(clk), .rst(rst), .req(req), .level(level), .ser(ser)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // sink: counts words, flags index gaps or wrong levels
    always @(posedge clk)
    begin
        if (bit_valid === 1'b1 && bit_ready === 1'b1)
        begin
            if (bit_index !== got[8:0] || bit_value !== level)
                bad++;
            got++;
        end
        if (req === 1'b1)
            req_hi++;
    end

    task cmp(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, act, exp);
        end
    endtask : cmp

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {20'h00000, a};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd_q     = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // mode 0 ready, 1 ready 5 of 8 cycles, 2 one long stall that overruns
    task line(input logic [5:0] ln, input logic lv, input int mode, input int n);
        got          = 0;
        bad          = 0;
        req_hi       = 0;
        level       <= lv;
        hsync_lead  <= 1'b1;
        line_number <= ln;
        @(posedge clk);
        hsync_lead <= 1'b0;
        for (int k = 0; k < n; k++)
        begin
            bit_ready <= mode == 1 ? k % 8 < 5 : mode != 2 || k < 400 || k > 430;
            @(posedge clk);
        end
        bit_ready <= 1'b1;
    endtask : line

    task t_regs;
        apb(1'b0, `TVI_REG_CTRL, 32'h0);
        cmp(rd_q, `TVI_CTRL_RESET);
        apb(1'b0, `TVI_REG_LINE_SEL_HI, 32'h0);
        cmp(rd_q, `TVI_LINE_SEL_RESET);
        apb(1'b0, 12'h020, 32'h0);
        cmp({rd_q[30:0], last_err}, 32'h0000_0001);
        apb(1'b1, `TVI_REG_CTRL, 32'h0000_0001);
        apb(1'b1, `TVI_REG_REQ_TIMING, 32'h0708_0064);
        apb(1'b1, `TVI_REG_LINE_SEL_LO, 32'h0000_0020);
        apb(1'b0, `TVI_REG_REQ_TIMING, 32'h0);
        cmp(rd_q, 32'h0708_0064);
        $display("t_regs done");
    endtask : t_regs

    task t_line;
        for (int i = 0; i < 2; i++)
        begin
            line(6'h05, i[0], 0, 1900);
            cmp(got, 360);
            cmp(bad, 0);
            apb(1'b0, `TVI_REG_STATUS, 32'h0);
            cmp(rd_q & 32'h0013_0000, 32'h0);
        end
        $display("t_line done");
    endtask : t_line

    task t_skip;
        // width field of one trims the line by eight bits
        apb(1'b1, `TVI_REG_CTRL, 32'h0000_0011);
        line(6'h05, 1'b1, 0, 1900);
        cmp(got, 352);
        cmp(bad, 0);
        line(6'h06, 1'b1, 0, 1900);
        cmp(got + req_hi, 0);
        apb(1'b1, `TVI_REG_CTRL, 32'h0);
        line(6'h05, 1'b1, 0, 1900);
        cmp(got + req_hi, 0);
        line(6'h05, 1'b0, 0, 700);
        apb(1'b1, `TVI_REG_CTRL, 32'h0000_0001);
        line(6'h05, 1'b0, 0, 700);
        apb(1'b1, `TVI_REG_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        cmp({insert_active, req, got > 50 && got < 360}, 3'b001);
        apb(1'b1, `TVI_REG_CTRL, 32'h0000_0001);
        $display("t_skip done");
    endtask : t_skip

    task t_stall;
        line(6'h05, 1'b1, 1, 1900);
        cmp(got, 360);
        cmp(bad, 0);
        line(6'h05, 1'b1, 2, 1900);
        apb(1'b0, `TVI_REG_STATUS, 32'h0);
        cmp({rd_q[20], bad > 0}, 2'b11);
        $display("t_stall done");
    endtask : t_stall

    task test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        {rst, bit_ready} = 2'b11;
        {psel, penable, pwrite, hsync_lead, level} = 5'h00;
        {paddr, pwdata, line_number} = 70'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_line;
        t_skip;
        t_stall;
        test_done;
    end

    // over twice the expected run of some 15000 cycles
    initial
    begin
        #1000000;
        errors++;
        test_done;
    end
endmodule : tvi_inserter_bench

bind tvi_inserter tvi_chk chk
(
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsync_lead(hsync_lead), .line_number(line_number),
    .text_serial_input(text_serial_input), .text_request_out(text_request_out),
    .bit_valid(bit_valid), .bit_ready(bit_ready), .bit_value(bit_value),
    .bit_index(bit_index), .insert_active(insert_active)
);
`default_nettype wire
